// [dv/hmpm_host_model.sv]
// host model: level-sensing report reader and spi frame source
`timescale 1ns/1ps
module hmpm_host_model (
  input wire ref_clk,
  input wire irq_n,
  input wire rd_en,
  input wire go,
  output reg report_read,
  output reg link_clk,
  output reg sel_n
);
  initial begin
    report_read = 0;
    link_clk = 0;
    sel_n = 1;
  end
  // level sensing, so a burst of reports is drained, not just one
  always @(posedge ref_clk) begin
    report_read <= #5 rd_en && !irq_n && !report_read;
  end
  // link clock stands still outside a frame
  always @(posedge go) begin
    sel_n = 0;
    repeat (8) begin
      #400 link_clk = 1;
      #400 link_clk = 0;
    end
    #400 sel_n = 1;
  end
endmodule // hmpm_host_model

// [dv/hmpm_pin_mux_props.sv]
// concurrent checks on the pin mux ports
`timescale 1ns/1ps
`include "hmpm_map.vh"
module hmpm_pin_mux_props #(
  parameter CNT_W = 8
) (
  input wire ref_clk,
  input wire nrst,
  input wire report_push,
  input wire report_read,
  input wire [CNT_W-1:0] pending_count_ff,
  input wire host_report_irq_n_o_ff,
  input wire host_report_irq_n_oe_ff,
  input wire [`HMPM_HMODE_W-1:0] host_mode_ff,
  input wire strap_valid_ff,
  input wire host_lin_tx,
  input wire host_serial_clock_o_ff,
  input wire host_serial_clock_oe_ff,
  input wire [`HMPM_MMODE_W-1:0] master_mode,
  input wire parallel_out_0,
  input wire master_spi_clock,
  input wire master_port_pin0_o_ff,
  input wire master_port_pin0_oe_ff,
  input wire master_port_pin1_o_ff,
  input wire master_port_pin1_oe_ff,
  input wire master_port_pin2_oe_ff,
  input wire master_port_pin3_oe_ff
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // lin mode may lend the irq pin to the transceiver, so skip it there
  wire not_lin = host_mode_ff != `HMPM_HMODE_LIN;
  sequence s_read_one;
    report_read && !report_push && pending_count_ff != 0;
  endsequence
  sequence s_read_last;
    s_read_one ##0 pending_count_ff == 1 && not_lin;
  endsequence
  irq_on_a: assert property ((pending_count_ff != 0 && not_lin) |->
    host_report_irq_n_oe_ff && !host_report_irq_n_o_ff) else $error("irq");
  irq_off_a: assert property ((pending_count_ff == 0 && not_lin) |->
    !host_report_irq_n_oe_ff) else $error("irq not released");
  read_dec_a: assert property (s_read_one |=>
    pending_count_ff == $past(pending_count_ff) - 1'b1) else $error("read");
  last_read_a: assert property (s_read_last |=>
    !host_report_irq_n_oe_ff) else $error("irq held after last read");
  lin_tx_a: assert property ((strap_valid_ff && !not_lin) |=>
    host_serial_clock_oe_ff && host_serial_clock_o_ff == $past(host_lin_tx))
    else $error("lin tx");
  strap_hold_a: assert property (strap_valid_ff |=>
    strap_valid_ff && $stable(host_mode_ff)) else $error("strap moved");
  pin0_gpio_a: assert property (master_mode == `HMPM_MMODE_GPIO |=>
    master_port_pin0_oe_ff && master_port_pin0_o_ff == $past(parallel_out_0))
    else $error("pin0");
  pin1_spi_a: assert property (master_mode == `HMPM_MMODE_SPI |=>
    master_port_pin1_oe_ff && master_port_pin1_o_ff == $past(master_spi_clock))
    else $error("pin1");
  pin2_input_a: assert property (master_mode != `HMPM_MMODE_GPIO |=>
    !master_port_pin2_oe_ff) else $error("pin2 driven");
  pin3_unused_a: assert property ((master_mode == `HMPM_MMODE_I2C ||
    master_mode == 2'h3) |=> !master_port_pin3_oe_ff) else $error("pin3");
endmodule // hmpm_pin_mux_props
bind hmpm_pin_mux hmpm_pin_mux_props #(.CNT_W(CNT_W)) i_props (
  .ref_clk(ref_clk),
  .nrst(nrst),
  .report_push(report_push),
  .report_read(report_read),
  .pending_count_ff(pending_count_ff),
  .host_report_irq_n_o_ff(host_report_irq_n_o_ff),
  .host_report_irq_n_oe_ff(host_report_irq_n_oe_ff),
  .host_mode_ff(host_mode_ff),
  .strap_valid_ff(strap_valid_ff),
  .host_lin_tx(host_lin_tx),
  .host_serial_clock_o_ff(host_serial_clock_o_ff),
  .host_serial_clock_oe_ff(host_serial_clock_oe_ff),
  .master_mode(master_mode),
  .parallel_out_0(parallel_out_0),
  .master_spi_clock(master_spi_clock),
  .master_port_pin0_o_ff(master_port_pin0_o_ff),
  .master_port_pin0_oe_ff(master_port_pin0_oe_ff),
  .master_port_pin1_o_ff(master_port_pin1_o_ff),
  .master_port_pin1_oe_ff(master_port_pin1_oe_ff),
  .master_port_pin2_oe_ff(master_port_pin2_oe_ff),
  .master_port_pin3_oe_ff(master_port_pin3_oe_ff)
);

// [dv/test_hmpm_pin_mux.sv]
// self-checking bench for the host and master port pin mux
`timescale 1ns/1ps
`include "hmpm_map.vh"
module test_hmpm_pin_mux;
  reg ref_clk = 0, nrst = 0, lin_sel = 0, push = 0, tx = 0, ten = 0;
  reg strap = 0, miso = 0, addr = 0, sda = 1, scl = 1, rd_en = 0, go = 0;
  reg spi = 0, p = 0, hdrv = 0;
  reg [1:0] mmode = 0;
  reg [3:0] v = 0;
  reg [15:0] rows [0:6];
  integer mismatches = 0, num_checks = 0, cyc = 0, i, k;
  wire rd, lclk, sel_n, d_o, d_oe, c_o, c_oe, s_o, s_oe, irq_o, irq_oe;
  wire m_irq, m_din, i2c_d, spi_c, ss_n, rx, sclin, amos, aaddr, m_sda, sv;
  wire [7:0] cnt;
  wire [1:0] hmode;
  wire [3:0] po, poe;
  wire irq_n = irq_oe ? irq_o : 1'b1;
  wire dpin = spi ? lclk : sda & !(d_oe & !d_o);
  wire cpin = spi ? sel_n : (c_oe ? c_o : scl);
  wire spin = s_oe ? s_o : strap;
  hmpm_pin_mux i_dut (.ref_clk(ref_clk), .nrst(nrst), .lin_sel(lin_sel),
    .lin_irq_as_enable(1'b1), .report_push(push), .report_read(rd),
    .pending_count_ff(cnt), .host_report_irq_n_o_ff(irq_o),
    .host_report_irq_n_oe_ff(irq_oe), .host_mode_ff(hmode),
    .strap_valid_ff(sv), .transceiver_enable(ten), .host_mode_strap_n_i(spin),
    .host_mode_strap_n_o_ff(s_o), .host_mode_strap_n_oe_ff(s_oe),
    .host_miso(miso), .host_addr_select(addr), .host_addr_ff(aaddr),
    .host_mosi_ff(amos), .host_serial_data_i(dpin),
    .host_serial_data_o_ff(d_o), .host_serial_data_oe_ff(d_oe),
    .host_i2c_data_out(1'b0), .host_i2c_data_drive(hdrv),
    .host_i2c_data_in_ff(i2c_d), .host_spi_clock_ff(spi_c),
    .host_lin_rx_ff(rx), .host_serial_clock_i(cpin),
    .host_serial_clock_o_ff(c_o), .host_serial_clock_oe_ff(c_oe),
    .host_lin_tx(tx), .host_i2c_clock_in_ff(sclin),
    .host_spi_select_n_ff(ss_n), .master_mode(mmode),
    .parallel_out_0(v[0]), .parallel_out_1(v[1]), .parallel_out_2(v[2]),
    .parallel_out_3(v[3]), .master_i2c_data_out(v[0]),
    .master_i2c_data_drive(1'b1), .master_i2c_clock_out(v[1]),
    .master_i2c_clock_drive(1'b1), .master_spi_dout(v[0]),
    .master_spi_clock(v[1]), .master_spi_select_n(v[3]),
    .master_port_pin0_i(poe[0] ? po[0] : 1'b1),
    // shared irq line: v[2] stands for the other slaves on it
    .master_port_pin2_i(poe[2] ? po[2] : v[2]),
    .master_port_pin0_o_ff(po[0]), .master_port_pin0_oe_ff(poe[0]),
    .master_port_pin1_o_ff(po[1]), .master_port_pin1_oe_ff(poe[1]),
    .master_port_pin2_o_ff(po[2]), .master_port_pin2_oe_ff(poe[2]),
    .master_port_pin3_o_ff(po[3]), .master_port_pin3_oe_ff(poe[3]),
    .master_i2c_data_in_ff(m_sda), .master_irq_in_n_ff(m_irq),
    .master_spi_din_ff(m_din));
  hmpm_host_model i_host (.ref_clk(ref_clk), .irq_n(irq_n), .rd_en(rd_en),
    .go(go), .report_read(rd), .link_clk(lclk), .sel_n(sel_n));
  task tick(input integer n);
    repeat (n) @(posedge ref_clk);
    #5;
  endtask
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task do_rst(input s, input l);
    nrst = 0;
    strap = s;
    spi = s;
    lin_sel = l;
    tick(8);
    nrst = 1;
    tick(8);
  endtask
  initial forever #50 ref_clk = ~ref_clk;
  // hang guard, well above the under two hundred cycles the run needs
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      mismatches = mismatches + 1;
      stop_test;
    end
  end
  initial begin
    // {mode, drive value, expected oe, expected o}
    rows[0] = 16'h0AFA;
    rows[1] = 16'h05F5;
    rows[2] = 16'h1210;
    rows[3] = 16'h1120;
    rows[4] = 16'h2BBB;
    rows[5] = 16'h24B0;
    rows[6] = 16'h3F00;
    do_rst(0, 0);
    chk("host_mode", hmode, `HMPM_HMODE_I2C);
    chk("strap_valid", sv, 1'b1);
    for (i = 0; i < 7; i = i + 1) begin
      mmode = rows[i][13:12];
      v = rows[i][11:8];
      tick(4);
      chk("pin_oe", poe, rows[i][7:4]);
      chk("pin_o", po & poe, rows[i][3:0]);
      if (mmode == `HMPM_MMODE_I2C) begin
        chk("master_irq", m_irq, v[2]);
        chk("master_sda_in", m_sda, !rows[i][4]);
      end
      if (mmode == `HMPM_MMODE_SPI)
        chk("master_din", m_din, v[2]);
    end
    push = 1;
    tick(3);
    push = 0;
    tick(1);
    chk("pending", cnt, 8'h03);
    chk("irq_n", irq_n, 0);
    rd_en = 1;
    k = 0;
    while (irq_n !== 1'b1 && k < 40) begin
      tick(1);
      k = k + 1;
    end
    tick(2);
    chk("pending", cnt, 8'h00);
    chk("irq_oe", irq_oe, 0);
    sda = 0;
    scl = 0;
    addr = 1;
    tick(4);
    chk("i2c_in", {i2c_d, sclin, aaddr}, 8'h01);
    hdrv = 1;
    tick(1);
    chk("sda_drive", {d_oe, d_o}, 8'h02);
    hdrv = 0;
    sda = 1;
    scl = 1;
    do_rst(1, 0);
    chk("host_mode", hmode, `HMPM_HMODE_SPI);
    miso = 1;
    go = 1;
    tick(6);
    chk("spi_select", ss_n, 0);
    chk("miso_mosi", {s_oe, s_o, amos}, 8'h07);
    k = 0;
    repeat (75) begin
      tick(1);
      if (spi_c === 1'b1 && p === 1'b0)
        k = k + 1;
      p = spi_c;
    end
    chk("spi_edges", k, 8'h08);
    do_rst(0, 1);
    tx = 1;
    sda = 0;
    tick(4);
    // irq pin carries the transceiver enable, low here
    chk("lin_pins", {c_oe, c_o, irq_oe, irq_o, rx}, 8'h1C);
    stop_test;
  end
endmodule // test_hmpm_pin_mux

// [verilog/hmpm_map.vh]
// constants for the host and master port pin mux
// Functional notes
// - drive slave interrupt low while any report waits for the host
// - release slave interrupt to high impedance when nothing is pending
// - each host read consumes one report; interrupt holds until all consumed
// - in LIN mode the interrupt pin may enable the transceiver instead
// - slave data and clock pin roles follow the strapped mode
// - slave pin 1: I2C data, SPI clock input, or LIN receive input
// - slave pin 2: I2C clock, SPI select input, or LIN transmit output
// - master port runs in one of three modes: GPIO, I2C, SPI
// - master pin 0: parallel out 0, I2C data, or SPI data out
// - master pin 1: parallel out 1, I2C clock, or SPI clock out
// - master pin 2: parallel out 2 in GPIO, SPI data in in SPI
// - master pin 2 in I2C mode is active-low interrupt input, pulled up
// - strap sampled at reset: low gives I2C, high SPI then MISO output
// - address select sets I2C address, becomes SPI data input in SPI
// - master pin 3: parallel out 3, unused in I2C, SPI select output
`ifndef HMPM_MAP_VH
`define HMPM_MAP_VH
`define HMPM_HMODE_W 2
`define HMPM_HMODE_I2C 2'h0
`define HMPM_HMODE_SPI 2'h1
`define HMPM_HMODE_LIN 2'h2
`define HMPM_MMODE_W 2
`define HMPM_MMODE_GPIO 2'h0
`define HMPM_MMODE_I2C 2'h1
`define HMPM_MMODE_SPI 2'h2
`define HMPM_STRAP_DLY 2'h2
`endif

// [verilog/hmpm_pin_mux.v]
// pin function mux for host slave port and master comms port
`timescale 1ns/1ps
`include "hmpm_map.vh"
module hmpm_pin_mux #(
  parameter CNT_W = 8
) (
  input wire ref_clk,
  input wire nrst,
  input wire lin_sel,
  input wire lin_irq_as_enable,
  input wire report_push,
  input wire report_read,
  output reg [CNT_W-1:0] pending_count_ff,
  output reg host_report_irq_n_o_ff,
  output reg host_report_irq_n_oe_ff,
  output reg [`HMPM_HMODE_W-1:0] host_mode_ff,
  output reg strap_valid_ff,
  input wire transceiver_enable,
  input wire host_mode_strap_n_i,
  output reg host_mode_strap_n_o_ff,
  output reg host_mode_strap_n_oe_ff,
  input wire host_miso,
  input wire host_addr_select,
  output reg host_addr_ff,
  output reg host_mosi_ff,
  input wire host_serial_data_i,
  output reg host_serial_data_o_ff,
  output reg host_serial_data_oe_ff,
  input wire host_i2c_data_out,
  input wire host_i2c_data_drive,
  output reg host_i2c_data_in_ff,
  output reg host_spi_clock_ff,
  output reg host_lin_rx_ff,
  input wire host_serial_clock_i,
  output reg host_serial_clock_o_ff,
  output reg host_serial_clock_oe_ff,
  input wire host_lin_tx,
  output reg host_i2c_clock_in_ff,
  output reg host_spi_select_n_ff,
  input wire [`HMPM_MMODE_W-1:0] master_mode,
  input wire parallel_out_0,
  input wire parallel_out_1,
  input wire parallel_out_2,
  input wire parallel_out_3,
  input wire master_i2c_data_out,
  input wire master_i2c_data_drive,
  input wire master_i2c_clock_out,
  input wire master_i2c_clock_drive,
  input wire master_spi_dout,
  input wire master_spi_clock,
  input wire master_spi_select_n,
  input wire master_port_pin0_i,
  input wire master_port_pin2_i,
  output reg master_port_pin0_o_ff,
  output reg master_port_pin0_oe_ff,
  output reg master_port_pin1_o_ff,
  output reg master_port_pin1_oe_ff,
  output reg master_port_pin2_o_ff,
  output reg master_port_pin2_oe_ff,
  output reg master_port_pin3_o_ff,
  output reg master_port_pin3_oe_ff,
  output reg master_i2c_data_in_ff,
  output reg master_irq_in_n_ff,
  output reg master_spi_din_ff
);
  wire strap_s;
  wire addr_s;
  wire sda_s;
  wire scl_s;
  wire mpin0_s;
  wire mpin2_s;
  reg [1:0] strap_dly_ff;
  reg [`HMPM_HMODE_W-1:0] nxt_host_mode;
  reg [CNT_W-1:0] nxt_pending_count;
  reg [`HMPM_MMODE_W-1:0] mm;

  // pins from outside the clock domain
  hmpm_sync #(.RST_VAL(1'b0)) u_strap (
    .ref_clk(ref_clk), .nrst(nrst), .d(host_mode_strap_n_i), .q(strap_s));
  hmpm_sync #(.RST_VAL(1'b1)) u_addr (
    .ref_clk(ref_clk), .nrst(nrst), .d(host_addr_select), .q(addr_s));
  hmpm_sync #(.RST_VAL(1'b1)) u_sda (
    .ref_clk(ref_clk), .nrst(nrst), .d(host_serial_data_i), .q(sda_s));
  hmpm_sync #(.RST_VAL(1'b1)) u_scl (
    .ref_clk(ref_clk), .nrst(nrst), .d(host_serial_clock_i), .q(scl_s));
  hmpm_sync #(.RST_VAL(1'b1)) u_mp0 (
    .ref_clk(ref_clk), .nrst(nrst), .d(master_port_pin0_i), .q(mpin0_s));
  hmpm_sync #(.RST_VAL(1'b1)) u_mp2 (
    .ref_clk(ref_clk), .nrst(nrst), .d(master_port_pin2_i), .q(mpin2_s));

  // strap caught once, after the synchroniser has settled past reset
  always @* begin
    nxt_host_mode = host_mode_ff;
    if (!strap_valid_ff && strap_dly_ff == `HMPM_STRAP_DLY) begin
      if (lin_sel)
        nxt_host_mode = `HMPM_HMODE_LIN;
      else if (strap_s)
        nxt_host_mode = `HMPM_HMODE_SPI;
      else
        nxt_host_mode = `HMPM_HMODE_I2C;
    end
  end

  // saturating report counter; push and read together cancel
  always @* begin
    nxt_pending_count = pending_count_ff;
    if (report_push && !report_read) begin
      if (pending_count_ff != {CNT_W{1'b1}})
        nxt_pending_count = pending_count_ff + 1'b1;
    end else if (report_read && !report_push) begin
      if (pending_count_ff != {CNT_W{1'b0}})
        nxt_pending_count = pending_count_ff - 1'b1;
    end
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      strap_dly_ff <= 2'h0;
      strap_valid_ff <= 1'b0;
      host_mode_ff <= `HMPM_HMODE_I2C;
      pending_count_ff <= {CNT_W{1'b0}};
    end else begin
      if (strap_dly_ff != `HMPM_STRAP_DLY)
        strap_dly_ff <= strap_dly_ff + 2'h1;
      if (strap_dly_ff == `HMPM_STRAP_DLY)
        strap_valid_ff <= 1'b1;
      host_mode_ff <= nxt_host_mode;
      pending_count_ff <= nxt_pending_count;
    end
  end

  // host side pins
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      host_report_irq_n_o_ff <= 1'b0;
      host_report_irq_n_oe_ff <= 1'b0;
      host_mode_strap_n_o_ff <= 1'b0;
      host_mode_strap_n_oe_ff <= 1'b0;
      host_serial_data_o_ff <= 1'b0;
      host_serial_data_oe_ff <= 1'b0;
      host_serial_clock_o_ff <= 1'b0;
      host_serial_clock_oe_ff <= 1'b0;
      host_addr_ff <= 1'b1;
      host_mosi_ff <= 1'b1;
      host_i2c_data_in_ff <= 1'b1;
      host_spi_clock_ff <= 1'b0;
      host_lin_rx_ff <= 1'b1;
      host_i2c_clock_in_ff <= 1'b1;
      host_spi_select_n_ff <= 1'b1;
    end else begin
      // level only: the host must poll the pin, edges carry nothing
      if (host_mode_ff == `HMPM_HMODE_LIN && lin_irq_as_enable) begin
        host_report_irq_n_o_ff <= transceiver_enable;
        host_report_irq_n_oe_ff <= strap_valid_ff;
      end else begin
        host_report_irq_n_o_ff <= 1'b0;
        host_report_irq_n_oe_ff <=
          (nxt_pending_count != {CNT_W{1'b0}});
      end
      // strap pin turns into MISO only once SPI has been latched
      host_mode_strap_n_o_ff <= host_miso;
      host_mode_strap_n_oe_ff <= strap_valid_ff &&
        (host_mode_ff == `HMPM_HMODE_SPI);
      host_addr_ff <= (host_mode_ff == `HMPM_HMODE_I2C) ? addr_s
        : host_addr_ff;
      host_mosi_ff <= (host_mode_ff == `HMPM_HMODE_SPI) ? addr_s
        : 1'b1;
      case (host_mode_ff)
        `HMPM_HMODE_I2C: begin
          host_serial_data_o_ff <= 1'b0;
          host_serial_data_oe_ff <= host_i2c_data_drive &&
            !host_i2c_data_out;
          host_serial_clock_o_ff <= 1'b0;
          host_serial_clock_oe_ff <= 1'b0;
        end
        `HMPM_HMODE_LIN: begin
          host_serial_data_o_ff <= 1'b0;
          host_serial_data_oe_ff <= 1'b0;
          host_serial_clock_o_ff <= host_lin_tx;
          host_serial_clock_oe_ff <= strap_valid_ff;
        end
        default: begin
          host_serial_data_o_ff <= 1'b0;
          host_serial_data_oe_ff <= 1'b0;
          host_serial_clock_o_ff <= 1'b0;
          host_serial_clock_oe_ff <= 1'b0;
        end
      endcase
      host_i2c_data_in_ff <= (host_mode_ff == `HMPM_HMODE_I2C) ? sda_s
        : 1'b1;
      host_spi_clock_ff <= (host_mode_ff == `HMPM_HMODE_SPI) ? sda_s
        : 1'b0;
      host_lin_rx_ff <= (host_mode_ff == `HMPM_HMODE_LIN) ? sda_s
        : 1'b1;
      host_i2c_clock_in_ff <= (host_mode_ff == `HMPM_HMODE_I2C) ? scl_s
        : 1'b1;
      host_spi_select_n_ff <= (host_mode_ff == `HMPM_HMODE_SPI) ? scl_s
        : 1'b1;
    end
  end

  // master comms port; an unknown mode code falls back to all released
  always @* begin
    mm = master_mode;
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      master_port_pin0_o_ff <= 1'b0;
      master_port_pin0_oe_ff <= 1'b0;
      master_port_pin1_o_ff <= 1'b0;
      master_port_pin1_oe_ff <= 1'b0;
      master_port_pin2_o_ff <= 1'b0;
      master_port_pin2_oe_ff <= 1'b0;
      master_port_pin3_o_ff <= 1'b0;
      master_port_pin3_oe_ff <= 1'b0;
      master_i2c_data_in_ff <= 1'b1;
      master_irq_in_n_ff <= 1'b1;
      master_spi_din_ff <= 1'b0;
    end else begin
      case (mm)
        `HMPM_MMODE_GPIO: begin
          master_port_pin0_o_ff <= parallel_out_0;
          master_port_pin0_oe_ff <= 1'b1;
          master_port_pin1_o_ff <= parallel_out_1;
          master_port_pin1_oe_ff <= 1'b1;
          master_port_pin2_o_ff <= parallel_out_2;
          master_port_pin2_oe_ff <= 1'b1;
          master_port_pin3_o_ff <= parallel_out_3;
          master_port_pin3_oe_ff <= 1'b1;
        end
        `HMPM_MMODE_I2C: begin
          // open drain: only ever pull low
          master_port_pin0_o_ff <= 1'b0;
          master_port_pin0_oe_ff <= master_i2c_data_drive &&
            !master_i2c_data_out;
          master_port_pin1_o_ff <= 1'b0;
          master_port_pin1_oe_ff <= master_i2c_clock_drive &&
            !master_i2c_clock_out;
          master_port_pin2_o_ff <= 1'b0;
          master_port_pin2_oe_ff <= 1'b0;
          master_port_pin3_o_ff <= 1'b0;
          master_port_pin3_oe_ff <= 1'b0;
        end
        `HMPM_MMODE_SPI: begin
          master_port_pin0_o_ff <= master_spi_dout;
          master_port_pin0_oe_ff <= 1'b1;
          master_port_pin1_o_ff <= master_spi_clock;
          master_port_pin1_oe_ff <= 1'b1;
          master_port_pin2_o_ff <= 1'b0;
          master_port_pin2_oe_ff <= 1'b0;
          master_port_pin3_o_ff <= master_spi_select_n;
          master_port_pin3_oe_ff <= 1'b1;
        end
        default: begin
          master_port_pin0_o_ff <= 1'b0;
          master_port_pin0_oe_ff <= 1'b0;
          master_port_pin1_o_ff <= 1'b0;
          master_port_pin1_oe_ff <= 1'b0;
          master_port_pin2_o_ff <= 1'b0;
          master_port_pin2_oe_ff <= 1'b0;
          master_port_pin3_o_ff <= 1'b0;
          master_port_pin3_oe_ff <= 1'b0;
        end
      endcase
      master_i2c_data_in_ff <= (mm == `HMPM_MMODE_I2C) ? mpin0_s : 1'b1;
      // shared line: who asserted is asked over I2C, not decoded here
      master_irq_in_n_ff <= (mm == `HMPM_MMODE_I2C) ? mpin2_s
        : 1'b1;
      master_spi_din_ff <= (mm == `HMPM_MMODE_SPI) ? mpin2_s
        : 1'b0;
    end
  end
endmodule // hmpm_pin_mux

// [verilog/hmpm_sync.v]
// two-stage synchroniser for one level
`timescale 1ns/1ps
module hmpm_sync #(
  parameter RST_VAL = 1'b0
) (
  input wire ref_clk,
  input wire nrst,
  input wire d,
  output wire q
);
  reg meta_ff;
  reg sync_ff;
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end
  assign q = sync_ff;
endmodule // hmpm_sync
